// [hw/sbp_pkg.sv]
// constants and types for the second serial port with clock switchback
package sbp_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_CTRL = 8'hC0;
   localparam logic [7:0] IDX_BUF = 8'hC1;
   localparam logic [7:0] IDX_PMR = 8'hC4;
   localparam logic [7:0] IDX_STATUS = 8'hC5;
   localparam logic [7:0] IDX_IRQ_STAT = 8'hD8;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hD9;
   localparam logic [7:0] IDX_CFG = 8'hDA;
   localparam logic [7:0] IDX_BAUD = 8'hDB;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [11:0] ADR_BUF = {2'h0, IDX_BUF, 2'h0};
   localparam logic [11:0] ADR_PMR = {2'h0, IDX_PMR, 2'h0};
   localparam logic [11:0] ADR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
   localparam logic [11:0] ADR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] ADR_CFG = {2'h0, IDX_CFG, 2'h0};
   localparam logic [11:0] ADR_BAUD = {2'h0, IDX_BAUD, 2'h0};

   // port_b_control field positions
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_MP = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TB8 = 3;
   localparam int CTL_RB8 = 2;
   localparam int CTL_TI = 1;
   localparam int CTL_RI = 0;
   // power_clock_divide_control field positions
   localparam int PMR_CD_HI = 7;
   localparam int PMR_CD_LO = 6;
   localparam int PMR_SWB = 5;
   // activity_and_priority_status field positions
   localparam int STS_TX_ACT = 3;
   localparam int STS_RX_ACT = 2;
   // interrupt status and mask field positions
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_FE = 2;
   // configuration field positions
   localparam int CFG_FE_SEL = 0;
   localparam int CFG_DOUBLE = 1;

   // frame modes
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_ASYNC10 = 2'h1;
   localparam logic [1:0] MODE_ASYNC11_FIX = 2'h2;
   localparam logic [1:0] MODE_ASYNC11_VAR = 2'h3;

   // clock divide codes and last count of each machine cycle
   localparam logic [1:0] CD_RSVD = 2'h0;
   localparam logic [1:0] CD_DIV4 = 2'h1;
   localparam logic [1:0] CD_DIV64 = 2'h2;
   localparam logic [1:0] CD_DIV1024 = 2'h3;
   localparam logic [9:0] MC_LAST_4 = 10'h003;
   localparam logic [9:0] MC_LAST_64 = 10'h03F;
   localparam logic [9:0] MC_LAST_1024 = 10'h3FF;

   // mode 0 bit time: 12 or 4 clocks, clock low up to the half count
   localparam logic [3:0] M0_LAST_SLOW = 4'hB;
   localparam logic [3:0] M0_HALF_SLOW = 4'h5;
   localparam logic [3:0] M0_LAST_FAST = 4'h3;
   localparam logic [3:0] M0_HALF_FAST = 4'h1;

   // async oversampling: 16 ticks per bit, sampled at the middle
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] DATA_LAST = 4'h7;
   // mode 2 tick spacing: 64 clocks per bit is 4 per tick, 32 is 2
   localparam logic [15:0] M2_TICK_LAST_SLOW = 16'h0003;
   localparam logic [15:0] M2_TICK_LAST_FAST = 16'h0001;

   // reset values
   localparam logic [1:0] CD_RST = CD_DIV4;
   localparam logic [15:0] BAUD_RST = 16'h0001;

   // frame phase, gray along idle-start-data-ninth-stop
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_START = 3'h1,
      PH_DATA = 3'h3,
      PH_NINTH = 3'h2,
      PH_STOP = 3'h6
   } sbp_phase_e;

endpackage

// [hw/sbp_uart.sv]
// second serial port with register bus, framing modes and machine-cycle switchback
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sbp_uart (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RXD_IN,
   output logic RXD_OUT,
   output logic RXD_OE_B,
   output logic TXD_OUT,
   input wire logic EXT_INT_TAKEN,
   output logic IRQ,
   output logic [1:0] CYCLE_DIVIDE,
   output logic MCYC_TICK
);

   typedef struct packed {
      logic [1:0] mode;
      logic mp;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic fe;
      logic fe_sel;
      logic dbl;
      logic [15:0] baud;
      logic [1:0] cd;
      logic divide_switchback_enable;
      logic sw_pend;
      logic [7:0] tx_buf;
      logic [7:0] rx_buf;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic s1;
      logic s2;
      logic s3;
      logic rxd_lvl;
      logic [15:0] tick_cnt;
      sbp_pkg::sbp_phase_e tx_ph;
      logic [7:0] tx_sh;
      logic [3:0] tx_bit;
      logic [3:0] tx_ovs;
      logic tx_act;
      sbp_pkg::sbp_phase_e rx_ph;
      logic [7:0] rx_sh;
      logic rx_9;
      logic [3:0] rx_bit;
      logic [3:0] rx_ovs;
      logic rx_act;
      logic [3:0] m0_cnt;
      logic txd;
      logic rxd_out;
      logic rxd_oe_b;
      logic irq;
      logic [9:0] mc_cnt;
      logic mc_tick;
   } sbp_state_s;

   sbp_state_s q;
   sbp_state_s n;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic: bus, registers, serial engines, clock divider
   always_comb begin
      logic [15:0] tick_last;
      logic [3:0] m0_last;
      logic [3:0] m0_half;
      logic [9:0] mc_last;
      logic tick;
      logic fall;
      logic acc;
      logic wr;
      logic tx_go;
      logic accept;
      logic [31:0] d;
      logic [31:0] rd;
      logic hit;
      tick_last = q.baud;
      m0_last = sbp_pkg::M0_LAST_SLOW;
      m0_half = sbp_pkg::M0_HALF_SLOW;
      mc_last = sbp_pkg::MC_LAST_4;
      tick = 1'b0;
      fall = 1'b0;
      acc = PSEL & PENABLE;
      wr = acc & q.pready & PWRITE;
      tx_go = 1'b0;
      accept = 1'b0;
      d = PWDATA;
      rd = 32'h0000_0000;
      hit = 1'b1;
      n = q;
      n.mc_tick = 1'b0;

      // three-stage sync; level changes once stages two and three agree
      n.s1 = RXD_IN;
      n.s2 = q.s1;
      n.s3 = q.s2;
      if (q.s2 == q.s3) begin
         n.rxd_lvl = q.s3;
      end
      fall = q.rxd_lvl & (q.s2 == q.s3) & ~q.s3;

      // read mux and decode; unmapped offsets answer zero with an error
      // read side of buffer
      unique case (PADDR)
         sbp_pkg::ADR_CTRL: rd = {24'h0, (q.fe_sel ? q.fe : q.mode[1]), q.mode[0], q.mp,
                                  q.ren, q.tb8, q.rb8, q.ti, q.ri};
         sbp_pkg::ADR_BUF: rd = {24'h0, q.rx_buf};
         sbp_pkg::ADR_PMR: rd = {24'h0, q.cd, q.divide_switchback_enable, 5'h00};
         sbp_pkg::ADR_STATUS: rd = {28'h0, q.tx_act, q.rx_act, 2'h0};
         sbp_pkg::ADR_IRQ_STAT: rd = {29'h0, q.ist};
         sbp_pkg::ADR_IRQ_MASK: rd = {29'h0, q.imask};
         sbp_pkg::ADR_CFG: rd = {30'h0, q.dbl, q.fe_sel};
         sbp_pkg::ADR_BAUD: rd = {16'h0, q.baud};
         default: hit = 1'b0;
      endcase

      // one wait state: pready rises in the second access cycle
      n.pready = acc & ~q.pready;
      if (acc & ~q.pready) begin
         n.prdata = PWRITE ? 32'h0000_0000 : rd;
         n.pslverr = ~hit;
      end else begin
         n.pslverr = 1'b0;
      end

      // register writes first, so hardware sets below win over clears
      if (wr & hit) begin
         unique case (PADDR)
            sbp_pkg::ADR_CTRL: begin
               // with fe_sel set, top bit is error flag, software may only clear
               if (q.fe_sel) begin
                  if (!d[sbp_pkg::CTL_MODE_HI]) begin
                     n.fe = 1'b0;
                  end
               end else begin
                  n.mode[1] = d[sbp_pkg::CTL_MODE_HI];
               end
               n.mode[0] = d[sbp_pkg::CTL_MODE_LO];
               n.mp = d[sbp_pkg::CTL_MP];
               n.ren = d[sbp_pkg::CTL_REN];
               n.tb8 = d[sbp_pkg::CTL_TB8];
               n.rb8 = d[sbp_pkg::CTL_RB8];
               // flags: writing zero clears, writing one is ignored
               if (!d[sbp_pkg::CTL_TI]) begin
                  n.ti = 1'b0;
               end
               if (!d[sbp_pkg::CTL_RI]) begin
                  n.ri = 1'b0;
               end
            end
            sbp_pkg::ADR_BUF: begin
               n.tx_buf = d[7:0];
               tx_go = 1'b1;
            end
            sbp_pkg::ADR_PMR: begin
               // divide frozen while active under switchback
               if (!(q.divide_switchback_enable && (q.tx_act || q.rx_act)) &&
                   d[sbp_pkg::PMR_CD_HI:sbp_pkg::PMR_CD_LO] != sbp_pkg::CD_RSVD) begin
                  n.cd = d[sbp_pkg::PMR_CD_HI:sbp_pkg::PMR_CD_LO];
               end
               n.divide_switchback_enable = d[sbp_pkg::PMR_SWB];
            end
            sbp_pkg::ADR_IRQ_STAT: n.ist = q.ist & ~d[2:0];
            sbp_pkg::ADR_IRQ_MASK: n.imask = d[2:0];
            sbp_pkg::ADR_CFG: begin
               n.fe_sel = d[sbp_pkg::CFG_FE_SEL];
               n.dbl = d[sbp_pkg::CFG_DOUBLE];
            end
            sbp_pkg::ADR_BAUD: n.baud = d[15:0];
            default: n.baud = q.baud;
         endcase
      end

      // oversample tick: fixed 64/32 clocks per bit in mode 2, else programmable
      // bit rate per mode
      if (q.mode == sbp_pkg::MODE_ASYNC11_FIX) begin
         tick_last = q.dbl ? sbp_pkg::M2_TICK_LAST_FAST : sbp_pkg::M2_TICK_LAST_SLOW;
      end
      if (q.tick_cnt >= tick_last) begin
         n.tick_cnt = 16'h0000;
         tick = 1'b1;
      end else begin
         n.tick_cnt = q.tick_cnt + 16'h0001;
      end

      // mode 0 shift clock is oscillator /4 or /12
      if (q.mp) begin
         m0_last = sbp_pkg::M0_LAST_FAST;
         m0_half = sbp_pkg::M0_HALF_FAST;
      end

      ////////////////////////////////////////////////////////////////////////////
      // transmitter; a write while busy is dropped rather than corrupt a frame
      // lsb first, with start 0 and stop 1 in modes 1 to 3
      unique case (q.tx_ph)
         sbp_pkg::PH_IDLE: begin
            if (tx_go && q.rx_ph == sbp_pkg::PH_IDLE) begin
               n.tx_sh = d[7:0];
               n.tx_bit = 4'h0;
               n.tx_ovs = 4'h0;
               n.tx_act = 1'b1;
               if (q.mode == sbp_pkg::MODE_SYNC) begin
                  n.tx_ph = sbp_pkg::PH_DATA;
                  n.m0_cnt = 4'h0;
                  n.rxd_oe_b = 1'b0;
                  n.rxd_out = d[0];
                  n.txd = 1'b0;
               end else begin
                  n.tx_ph = sbp_pkg::PH_START;
                  n.txd = 1'b0;
               end
            end
         end
         sbp_pkg::PH_DATA: begin
            if (q.mode == sbp_pkg::MODE_SYNC) begin
               n.m0_cnt = q.m0_cnt + 4'h1;
               n.txd = (q.m0_cnt >= m0_half);
               if (q.m0_cnt == m0_last) begin
                  n.m0_cnt = 4'h0;
                  n.txd = 1'b0;
                  if (q.tx_bit == sbp_pkg::DATA_LAST) begin
                     // mode 0 tx flag at end of bit eight
                     n.ti = 1'b1;
                     n.ist[sbp_pkg::IRQ_TX] = 1'b1;
                     n.tx_act = 1'b0;
                     n.tx_ph = sbp_pkg::PH_IDLE;
                     // released data pin returns to its idle high level
                     n.rxd_oe_b = 1'b1;
                     n.rxd_out = 1'b1;
                     n.txd = 1'b1;
                  end else begin
                     n.tx_bit = q.tx_bit + 4'h1;
                     n.tx_sh = {1'b1, q.tx_sh[7:1]};
                     n.rxd_out = q.tx_sh[1];
                  end
               end
            end else if (tick) begin
               n.tx_ovs = q.tx_ovs + 4'h1;
               if (q.tx_ovs == sbp_pkg::OVS_LAST) begin
                  if (q.tx_bit == sbp_pkg::DATA_LAST) begin
                     if (q.mode[1]) begin
                        n.tx_ph = sbp_pkg::PH_NINTH;
                        n.txd = q.tb8;
                     end else begin
                        // tx flag at start of stop bit
                        n.tx_ph = sbp_pkg::PH_STOP;
                        n.txd = 1'b1;
                        n.ti = 1'b1;
                        n.ist[sbp_pkg::IRQ_TX] = 1'b1;
                        n.tx_act = 1'b0;
                     end
                  end else begin
                     n.tx_bit = q.tx_bit + 4'h1;
                     n.tx_sh = {1'b1, q.tx_sh[7:1]};
                     n.txd = q.tx_sh[1];
                  end
               end
            end
         end
         sbp_pkg::PH_START, sbp_pkg::PH_NINTH, sbp_pkg::PH_STOP: begin
            if (tick) begin
               n.tx_ovs = q.tx_ovs + 4'h1;
               if (q.tx_ovs == sbp_pkg::OVS_LAST) begin
                  if (q.tx_ph == sbp_pkg::PH_START) begin
                     n.tx_ph = sbp_pkg::PH_DATA;
                     n.txd = q.tx_sh[0];
                  end else if (q.tx_ph == sbp_pkg::PH_NINTH) begin
                     // tx flag at start of stop bit
                     n.tx_ph = sbp_pkg::PH_STOP;
                     n.txd = 1'b1;
                     n.ti = 1'b1;
                     n.ist[sbp_pkg::IRQ_TX] = 1'b1;
                     n.tx_act = 1'b0;
                  end else begin
                     n.tx_ph = sbp_pkg::PH_IDLE;
                  end
               end
            end
         end
         default: n.tx_ph = sbp_pkg::PH_IDLE;
      endcase

      ////////////////////////////////////////////////////////////////////////////
      // receiver; mode 0 waits for a cleared flag so it does not free-run
      unique case (q.rx_ph)
         sbp_pkg::PH_IDLE: begin
            // frames accepted only with receive enable
            if (q.ren && q.tx_ph == sbp_pkg::PH_IDLE) begin
               if (q.mode == sbp_pkg::MODE_SYNC) begin
                  if (!q.ri && !tx_go) begin
                     n.rx_ph = sbp_pkg::PH_DATA;
                     n.rx_bit = 4'h0;
                     n.m0_cnt = 4'h0;
                     n.rx_act = 1'b1;
                     n.txd = 1'b0;
                  end
               end else if (fall) begin
                  n.rx_ph = sbp_pkg::PH_START;
                  n.rx_ovs = 4'h0;
                  n.rx_act = 1'b1;
                  n.sw_pend = q.divide_switchback_enable;
               end
            end
         end
         sbp_pkg::PH_DATA: begin
            if (q.mode == sbp_pkg::MODE_SYNC) begin
               n.m0_cnt = q.m0_cnt + 4'h1;
               n.txd = (q.m0_cnt >= m0_half);
               if (q.m0_cnt == m0_half) begin
                  n.rx_sh = {q.rxd_lvl, q.rx_sh[7:1]};
               end
               if (q.m0_cnt == m0_last) begin
                  n.m0_cnt = 4'h0;
                  n.txd = 1'b0;
                  if (q.rx_bit == sbp_pkg::DATA_LAST) begin
                     // mode 0 rx flag at end of bit eight
                     n.ri = 1'b1;
                     n.ist[sbp_pkg::IRQ_RX] = 1'b1;
                     n.rx_buf = q.rx_sh;
                     n.rx_act = 1'b0;
                     n.rx_ph = sbp_pkg::PH_IDLE;
                     n.txd = 1'b1;
                  end else begin
                     n.rx_bit = q.rx_bit + 4'h1;
                  end
               end
            end else if (tick) begin
               n.rx_ovs = q.rx_ovs + 4'h1;
               if (q.rx_ovs == sbp_pkg::OVS_MID) begin
                  n.rx_sh = {q.rxd_lvl, q.rx_sh[7:1]};
               end
               if (q.rx_ovs == sbp_pkg::OVS_LAST) begin
                  if (q.rx_bit == sbp_pkg::DATA_LAST) begin
                     n.rx_ph = q.mode[1] ? sbp_pkg::PH_NINTH : sbp_pkg::PH_STOP;
                  end else begin
                     n.rx_bit = q.rx_bit + 4'h1;
                  end
               end
            end
         end
         sbp_pkg::PH_START, sbp_pkg::PH_NINTH, sbp_pkg::PH_STOP: begin
            if (tick) begin
               n.rx_ovs = q.rx_ovs + 4'h1;
               if (q.rx_ovs == sbp_pkg::OVS_MID) begin
                  if (q.rx_ph == sbp_pkg::PH_START && q.rxd_lvl) begin
                     // false start: a glitch, not a frame
                     n.rx_ph = sbp_pkg::PH_IDLE;
                     n.rx_act = 1'b0;
                  end else if (q.rx_ph == sbp_pkg::PH_NINTH) begin
                     n.rx_9 = q.rxd_lvl;
                  end else if (q.rx_ph == sbp_pkg::PH_STOP) begin
                     // with mp set, ninth bit zero is dropped in modes 2/3 and bad stop is dropped in mode 1
                     accept = q.mode[1] ? (~q.mp | q.rx_9) : (~q.mp | q.rxd_lvl);
                     n.rx_ph = sbp_pkg::PH_IDLE;
                     n.rx_act = 1'b0;
                     if (accept) begin
                        // rx flag at middle of stop bit
                        n.ri = 1'b1;
                        n.ist[sbp_pkg::IRQ_RX] = 1'b1;
                        n.rx_buf = q.rx_sh;
                        // ninth bit in modes 2/3, stop bit in mode 1
                        n.rb8 = q.mode[1] ? q.rx_9 : q.rxd_lvl;
                     end
                     if (!q.rxd_lvl && q.fe_sel) begin
                        n.fe = 1'b1;
                        n.ist[sbp_pkg::IRQ_FE] = 1'b1;
                     end
                  end
               end
               if (q.rx_ovs == sbp_pkg::OVS_LAST && q.rx_ph != sbp_pkg::PH_STOP) begin
                  n.rx_bit = 4'h0;
                  n.rx_ph = (q.rx_ph == sbp_pkg::PH_START) ? sbp_pkg::PH_DATA
                                                            : sbp_pkg::PH_STOP;
               end
            end
         end
         default: n.rx_ph = sbp_pkg::PH_IDLE;
      endcase

      ////////////////////////////////////////////////////////////////////////////
      // machine cycle divider; reserved code behaves as divide by 4
      // clocks per machine cycle
      unique case (q.cd)
         sbp_pkg::CD_DIV64: mc_last = sbp_pkg::MC_LAST_64;
         sbp_pkg::CD_DIV1024: mc_last = sbp_pkg::MC_LAST_1024;
         default: mc_last = sbp_pkg::MC_LAST_4;
      endcase
      if (q.mc_cnt >= mc_last) begin
         n.mc_cnt = 10'h000;
         n.mc_tick = 1'b1;
      end else begin
         n.mc_cnt = q.mc_cnt + 10'h001;
      end
      // switch lands at the next machine cycle boundary
      if (q.sw_pend && q.mc_tick) begin
         n.cd = sbp_pkg::CD_DIV4;
         n.sw_pend = 1'b0;
      end
      // with switchback enabled, a taken external interrupt forces divide by 4 at once
      if (EXT_INT_TAKEN && q.divide_switchback_enable) begin
         n.cd = sbp_pkg::CD_DIV4;
      end

      // level interrupt from sticky status gated by mask
      n.irq = |(n.ist & n.imask);

      // synchronous reset: constants only
      if (!RST_B) begin
         n = '0;
         n.cd = sbp_pkg::CD_RST;
         n.baud = sbp_pkg::BAUD_RST;
         n.tx_ph = sbp_pkg::PH_IDLE;
         n.rx_ph = sbp_pkg::PH_IDLE;
         n.s1 = 1'b1;
         n.s2 = 1'b1;
         n.s3 = 1'b1;
         n.rxd_lvl = 1'b1;
         n.txd = 1'b1;
         n.rxd_out = 1'b1;
         n.rxd_oe_b = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLOCK) begin
      q <= n;
   end

   // outputs straight from state flops
   assign PRDATA = q.prdata;
   assign PREADY = q.pready;
   assign PSLVERR = q.pslverr;
   assign RXD_OUT = q.rxd_out;
   assign RXD_OE_B = q.rxd_oe_b;
   assign TXD_OUT = q.txd;
   assign IRQ = q.irq;
   assign CYCLE_DIVIDE = q.cd;
   assign MCYC_TICK = q.mc_tick;

endmodule

`default_nettype wire

// [sim/sbp_asserts.sv]
// port checker for the second serial port
`timescale 1ns/100ps
`default_nettype none
module sbp_asserts (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic RXD_OUT,
   input wire logic RXD_OE_B,
   input wire logic TXD_OUT,
   input wire logic EXT_INT_TAKEN,
   input wire logic [1:0] CYCLE_DIVIDE
);
   logic swb_ff;
   // switchback copy from committed writes; the bit is not visible at the pins
   always_ff @(posedge CLOCK) begin
      if (!RST_B) swb_ff <= 1'b0;
      else if (PREADY && PWRITE && PADDR == sbp_pkg::ADR_PMR) swb_ff <= PWDATA[5];
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence s_acc; PSEL && $rose(PENABLE); endsequence
   property p_rdy; s_acc |=> PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after access");
   property p_own; PREADY |-> PSEL && PENABLE; endproperty
   a_own: assert property (p_own) else $error("ready outside access");
   property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad error answer");
   property p_buf; PREADY && PADDR == sbp_pkg::ADR_BUF |-> !PSLVERR; endproperty
   a_buf: assert property (p_buf) else $error("buffer refused");
   property p_rsv; CYCLE_DIVIDE != sbp_pkg::CD_RSVD; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved divide");
   property p_ext; EXT_INT_TAKEN && swb_ff |=> CYCLE_DIVIDE == sbp_pkg::CD_DIV4; endproperty
   a_ext: assert property (p_ext) else $error("no switchback");
   property p_m0; $fell(RXD_OE_B) |-> !TXD_OUT ##1 !RXD_OE_B [*8]; endproperty
   a_m0: assert property (p_m0) else $error("short sync frame");
   property p_end; $rose(RXD_OE_B) |-> TXD_OUT && RXD_OUT; endproperty
   a_end: assert property (p_end) else $error("sync end not idle");
   property p_oe; RXD_OE_B |-> RXD_OUT; endproperty
   a_oe: assert property (p_oe) else $error("data out while released");
endmodule
bind sbp_uart sbp_asserts u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .RXD_OUT(RXD_OUT), .RXD_OE_B(RXD_OE_B), .TXD_OUT(TXD_OUT),
   .EXT_INT_TAKEN(EXT_INT_TAKEN), .CYCLE_DIVIDE(CYCLE_DIVIDE));
`default_nettype wire

// [sim/sbp_peer.sv]
// remote serial node: sends frames to the block and captures its frames
`timescale 1ns/100ps
`default_nettype none
module sbp_peer (
   input wire logic CLOCK,
   input wire logic tx_in,
   output logic line
);
   initial line = 1'b1;
   task automatic send(input logic [10:0] f, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         @(posedge CLOCK);
         line <= f[i];
         repeat (bt - 1) @(posedge CLOCK);
      end
   endtask
   // sample mid-bit, well clear of the edges
   task automatic rx(output logic [10:0] f, input int n, input int bt);
      f = 11'h0;
      @(negedge tx_in);
      repeat (bt / 2) @(negedge CLOCK);
      for (int i = 0; i < n; i++) begin
         f[i] = tx_in;
         repeat (bt) @(negedge CLOCK);
      end
   endtask
endmodule
`default_nettype wire

// [sim/sbp_uart_tb.sv]
// self-checking bench for the second serial port
`timescale 1ns/100ps
`default_nettype none
module sbp_uart_tb;
   logic CLOCK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic EXT_INT_TAKEN = 1'b0;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, RXD_IN, RXD_OUT, RXD_OE_B, TXD_OUT, IRQ, MCYC_TICK, se;
   logic [1:0] CYCLE_DIVIDE;
   logic [10:0] fr;
   int err_total = 0, n_tests = 0;
   sbp_uart dut (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT), .RXD_OE_B(RXD_OE_B), .TXD_OUT(TXD_OUT),
      .EXT_INT_TAKEN(EXT_INT_TAKEN), .IRQ(IRQ), .CYCLE_DIVIDE(CYCLE_DIVIDE), .MCYC_TICK(MCYC_TICK));
   sbp_peer peer (.CLOCK(CLOCK), .tx_in(TXD_OUT), .line(RXD_IN));
   initial forever #2.5 CLOCK = ~CLOCK;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t got %h want %h", $time, g, e);
      end
   endtask
   // one apb transfer; held until ready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1 && n < 40) begin
         @(posedge CLOCK);
         n++;
      end
      if (n >= 40) err_total++;
      rd = PRDATA;
      se = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic t_regs();
      apb(1'b1, sbp_pkg::ADR_PMR, 32'h0);
      apb(1'b0, sbp_pkg::ADR_PMR, 32'h0);
      chk(rd, 32'h40);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, se}, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_tx();
      apb(1'b1, sbp_pkg::ADR_PMR, 32'h60);
      apb(1'b1, sbp_pkg::ADR_CTRL, 32'hC8);
      fork
         peer.rx(fr, 11, 32);
         begin
            apb(1'b1, sbp_pkg::ADR_BUF, 32'hA5);
            apb(1'b1, sbp_pkg::ADR_PMR, 32'hA0);
            apb(1'b0, sbp_pkg::ADR_STATUS, 32'h0);
            chk(rd & 32'h8, 32'h8);
            apb(1'b0, sbp_pkg::ADR_PMR, 32'h0);
            chk(rd & 32'hE0, 32'h60);
         end
      join
      chk({21'h0, fr}, 32'h74A);
      apb(1'b0, sbp_pkg::ADR_CTRL, 32'h0);
      chk(rd, 32'hCA);
      apb(1'b0, sbp_pkg::ADR_STATUS, 32'h0);
      chk(rd & 32'h8, 32'h0);
      $display("test tx done");
   endtask
   task automatic t_rx();
      apb(1'b1, sbp_pkg::ADR_CTRL, 32'hB0);
      peer.send(11'h4AA, 11, 64);
      apb(1'b0, sbp_pkg::ADR_CTRL, 32'h0);
      chk(rd, 32'hB0);
      peer.send(11'h678, 11, 64);
      apb(1'b0, sbp_pkg::ADR_CTRL, 32'h0);
      chk(rd, 32'hB5);
      apb(1'b0, sbp_pkg::ADR_BUF, 32'h0);
      chk(rd, 32'h3C);
      chk({31'h0, IRQ}, 32'h0);
      apb(1'b1, sbp_pkg::ADR_IRQ_MASK, 32'h2);
      repeat (2) @(negedge CLOCK);
      chk({31'h0, IRQ}, 32'h1);
      apb(1'b1, sbp_pkg::ADR_IRQ_STAT, 32'h2);
      repeat (2) @(negedge CLOCK);
      chk({31'h0, IRQ}, 32'h0);
      apb(1'b1, sbp_pkg::ADR_CTRL, 32'hA0);
      peer.send(11'h7EE, 11, 64);
      apb(1'b0, sbp_pkg::ADR_CTRL, 32'h0);
      chk(rd, 32'hA0);
      $display("test rx done");
   endtask
   task automatic t_swb();
      apb(1'b1, sbp_pkg::ADR_PMR, 32'hA0);
      apb(1'b1, sbp_pkg::ADR_CTRL, 32'h90);
      peer.send(11'h7FE, 11, 64);
      chk({30'h0, CYCLE_DIVIDE}, 32'h1);
      apb(1'b1, sbp_pkg::ADR_PMR, 32'hE0);
      apb(1'b0, sbp_pkg::ADR_PMR, 32'h0);
      chk(rd & 32'hE0, 32'hE0);
      EXT_INT_TAKEN <= 1'b1;
      @(posedge CLOCK);
      EXT_INT_TAKEN <= 1'b0;
      @(negedge CLOCK);
      chk({30'h0, CYCLE_DIVIDE}, 32'h1);
      $display("test switchback done");
   endtask
   task automatic t_m0();
      logic [7:0] m;
      apb(1'b1, sbp_pkg::ADR_CTRL, 32'h20);
      fork
         apb(1'b1, sbp_pkg::ADR_BUF, 32'h81);
         for (int i = 0; i < 8; i++) begin
            @(posedge TXD_OUT);
            m[i] = RXD_OUT;
         end
      join
      @(posedge RXD_OE_B);
      chk({24'h0, m}, 32'h81);
      apb(1'b0, sbp_pkg::ADR_CTRL, 32'h0);
      chk(rd, 32'h22);
      $display("test sync done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge CLOCK);
      RST_B <= 1'b1;
      repeat (4) @(posedge CLOCK);
      t_regs();
      t_tx();
      t_rx();
      t_swb();
      t_m0();
      final_report();
   end
   // guard against a hang; the run needs well under 8000 cycles
   initial begin
      repeat (40000) @(posedge CLOCK);
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
